// [bench/mcd_decoder_properties.sv]
// Concurrent checks on the decoder's ports.
// Assumes one clock domain and a host that holds csb low until the answer.
`timescale 1ns/1ns
`default_nettype none
module mcd_decoder_properties #(
	parameter int unsigned CELL_COUNT = 36
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_link_sck,
	input wire logic i_link_csb_n,
	input wire logic i_link_sdi,
	input wire logic [3:0] i_device_address,
	input wire mcd_pkg::mcd_cmd_s o_cmd,
	input wire logic o_cmd_valid,
	input wire logic o_pec_error,
	input wire logic o_cmd_ignored,
	input wire logic o_frame_active
);
	// ----------------------------------------
	// Frame capture
	// ----------------------------------------
	logic sck_q;
	logic [5:0] cnt;
	logic [31:0] w;
	logic any;
	assign any = o_cmd_valid | o_pec_error | o_cmd_ignored;
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			sck_q <= 1'b0;
			cnt <= '0;
			w <= '0;
		end else begin
			sck_q <= i_link_sck;
			if (i_link_csb_n) begin
				cnt <= '0;
			end else if (i_link_sck && !sck_q && cnt != 6'h20) begin
				cnt <= cnt + 6'h01;
				w <= {w[30:0], i_link_sdi};
			end
		end
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_one_outcome: assert property ($onehot0({o_cmd_valid, o_pec_error, o_cmd_ignored}))
		else $error("more than one outcome pulse");
	a_cmd_holds: assert property ($changed(o_cmd) |-> o_cmd_valid)
		else $error("command changed without valid");
	a_answer_time: assert property ($rose(i_link_sck) && !i_link_csb_n && cnt == 6'h1F |-> ##[2:5] any)
		else $error("no outcome after last bit");
	a_bcast_flag: assert property (o_cmd_valid |-> o_cmd.broadcast == (w[31:27] == 5'h00))
		else $error("broadcast flag wrong");
	a_addr_match: assert property (o_cmd_valid && !o_cmd.broadcast |-> w[31] && w[30:27] == i_device_address)
		else $error("addressed command acted on with wrong address");
	a_mode_field: assert property (o_cmd_valid && o_cmd.kind >= mcd_pkg::K_CELL_CONV |-> o_cmd.mode == w[23:22])
		else $error("mode field wrong");
	a_cell_select: assert property (o_cmd_valid && o_cmd.kind == mcd_pkg::K_CELL_CONV |-> w[26:24] == 3'h4 && o_cmd.field_ok == (w[21:16] <= 6'h24 && w[21:16] <= CELL_COUNT))
		else $error("cell conversion decode wrong");
	a_pull_dir: assert property (o_cmd_valid && o_cmd.kind == mcd_pkg::K_OPEN_WIRE |-> w[26:25] == 2'h3 && o_cmd.test_current_direction == w[24])
		else $error("open wire decode wrong");
	a_stat_range: assert property (o_cmd_valid && o_cmd.kind == mcd_pkg::K_STAT_CONV |-> o_cmd.field_ok == (w[18:16] <= 3'h3))
		else $error("status channel range wrong");
	c_addressed: cover property (o_cmd_valid && !o_cmd.broadcast);
	c_pec_bad: cover property (o_pec_error);
	c_ignored: cover property (o_cmd_ignored);
endmodule
bind mcd_decoder mcd_decoder_properties #(.CELL_COUNT(CELL_COUNT)) u_props (.i_clock(i_clock), .i_rst(i_rst),
	.i_link_sck(i_link_sck), .i_link_csb_n(i_link_csb_n), .i_link_sdi(i_link_sdi),
	.i_device_address(i_device_address), .o_cmd(o_cmd), .o_cmd_valid(o_cmd_valid),
	.o_pec_error(o_pec_error), .o_cmd_ignored(o_cmd_ignored), .o_frame_active(o_frame_active));
`default_nettype wire

// [bench/mcd_decoder_tb.sv]
// Self-checking bench for the command decoder.
// Assumes the host model frames commands and a checker is bound in.
`timescale 1ns/1ns
`default_nettype none
module mcd_decoder_tb;
	logic i_clock, i_rst, sck, csb_n, sdi, v, pe, ig, fa;
	logic [3:0] addr;
	mcd_pkg::mcd_cmd_s o_cmd;
	int fails, comparisons, seed, i;
	logic [21:0] notes[$];
	logic [10:0] conv[16] = '{11'h400, 11'h424, 11'h425, 11'h430, 11'h53F, 11'h63F, 11'h7A5,
		11'h6C1, 11'h367, 11'h3A0, 11'h3F0, 11'h137, 11'h0B7, 11'h32B, 11'h36C, 11'h500};
	mcd_host host (.o_sck(sck), .o_csb_n(csb_n), .o_sdi(sdi));
	mcd_decoder dut (.i_clock(i_clock), .i_rst(i_rst), .i_link_sck(sck), .i_link_csb_n(csb_n),
		.i_link_sdi(sdi), .i_device_address(addr), .o_cmd(o_cmd), .o_cmd_valid(v),
		.o_pec_error(pe), .o_cmd_ignored(ig), .o_frame_active(fa));
	// ----------------------------------------
	// Expectations
	// ----------------------------------------
	function automatic logic [19:0] sm(input mcd_pkg::mcd_cmd_s x);
		logic [5:0] s;
		s = '0;
		case (x.kind)
			mcd_pkg::K_CELL_CONV, mcd_pkg::K_OPEN_WIRE: s = x.cell_select_field;
			mcd_pkg::K_AUX_CONV: s = {3'h0, x.aux_channel_field};
			mcd_pkg::K_STAT_CONV: s = {3'h0, x.status_channel_field};
			mcd_pkg::K_CELL_ST, mcd_pkg::K_AUX_ST, mcd_pkg::K_STAT_ST: s = {4'h0, x.selftest_pattern_field};
			default: s = '0;
		endcase
		return {x.kind, x.broadcast, x.group, x.field_ok, x.kind >= mcd_pkg::K_CELL_CONV ? x.mode : 2'h0,
			s, x.kind == mcd_pkg::K_OPEN_WIRE ? x.test_current_direction : 1'b0};
	endfunction

	function automatic mcd_pkg::mcd_cmd_s exp_cmd(input logic [10:0] c, input logic b);
		mcd_pkg::mcd_cmd_s e;
		e = '0;
		e.broadcast = b;
		e.mode = mcd_pkg::mcd_mode_e'(c[7:6]);
		e.field_ok = 1'b1;
		e.cell_select_field = c[5:0];
		e.aux_channel_field = c[2:0];
		e.status_channel_field = c[2:0];
		e.selftest_pattern_field = c[9:8];
		e.test_current_direction = c[8];
		if (c[10]) begin
			if (c[5:0] == 6'h3F && c[9] != c[8]) e.kind = mcd_pkg::K_CELL_ST;
			else if (c[9]) begin
				e.kind = mcd_pkg::K_OPEN_WIRE;
				e.field_ok = c[5:0] <= 6'h24;
			end else if (c[8]) e.kind = mcd_pkg::K_NONE;
			else if (c[5:0] == 6'h30) e.kind = mcd_pkg::K_CELL_SUM;
			else begin
				e.kind = mcd_pkg::K_CELL_CONV;
				e.field_ok = c[5:0] <= 6'h24;
			end
		end else if (c[5:0] == 6'h3F || c[5:0] == 6'h37) begin
			e.kind = c[3] ? mcd_pkg::K_STAT_ST : mcd_pkg::K_AUX_ST;
			e.field_ok = c[9] ^ c[8];
		end else if (c[9:8] == 2'h3) begin
			if (c[5:0] == 6'h30) e.kind = mcd_pkg::K_AUX_SUM;
			else if (c[5:3] == 3'h4) e.kind = mcd_pkg::K_AUX_CONV;
			else if (c[5:3] == 3'h5) begin
				e.kind = mcd_pkg::K_STAT_CONV;
				e.field_ok = c[2:0] <= 3'h3;
			end
		end else if (c[9:8] == 2'h0) begin
			if (c[7:0] >= 8'h04 && c[7:0] <= 8'h0C) begin
				e.kind = mcd_pkg::K_RD_CELL;
				e.group = c[3:0] - 4'h4;
			end else if (c[7:1] == 7'h08) begin
				e.kind = mcd_pkg::K_RD_AUX;
				e.group = c[3:0];
			end else if (c[7:0] >= 8'h14 && c[7:0] <= 8'h16) begin
				e.kind = mcd_pkg::K_RD_STAT;
				e.group = c[3:0] - 4'h4;
			end else case (c[7:0])
				8'h01: e.kind = mcd_pkg::K_WR_CFG;
				8'h02: e.kind = mcd_pkg::K_RD_CFG;
				8'h19: e.kind = mcd_pkg::K_CLR_CELL;
				8'h1A: e.kind = mcd_pkg::K_CLR_AUX;
				8'h1B: e.kind = mcd_pkg::K_CLR_STAT;
				8'h1C: e.kind = mcd_pkg::K_POLL;
				8'h1D: e.kind = mcd_pkg::K_DIAG;
				default: e.kind = mcd_pkg::K_NONE;
			endcase
		end
		return e;
	endfunction
	// ----------------------------------------
	// Drivers and checks
	// ----------------------------------------
	task automatic cmp(input logic [21:0] exp, input logic [21:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	// how: 0 broadcast, 1 own address, 2 other address, 3 bad prefix
	task automatic cmd(input logic [10:0] c, input logic [1:0] how);
		logic [15:0] w;
		mcd_pkg::mcd_cmd_s e;
		e = exp_cmd(c, how == 2'h0);
		case (how)
			2'h0: w = {5'h00, c};
			2'h1: w = {1'b1, addr, c};
			2'h2: w = {1'b1, ~addr, c};
			default: w = {1'b0, addr | 4'h1, c};
		endcase
		if (how >= 2'h2 || e.kind == mcd_pkg::K_NONE) notes.push_back({2'h2, 20'h0_0000});
		else notes.push_back({2'h1, sm(e)});
		host.send(w, 1'b0, 32);
	endtask

	always @(negedge i_clock) begin
		if (!i_rst && (v | pe | ig)) begin
			if (notes.size() == 0) cmp(22'h00_0000, {v ? 2'h1 : ig ? 2'h2 : 2'h3, 20'h0_0000});
			else cmp(notes.pop_front(), {v ? 2'h1 : ig ? 2'h2 : 2'h3, v ? sm(o_cmd) : 20'h0_0000});
			cmp(22'h00_0001, {21'h00_0000, fa});
		end
	end

	task automatic end_of_test();
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	initial begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end

	initial begin
		#200000;
		fails++;
		end_of_test();
	end

	initial begin
		seed = 17;
		i_rst = 1'b1;
		addr = 4'h9;
		repeat (8) @(posedge i_clock);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_clock);
		for (i = 0; i < 32; i++) cmd(11'(i), 2'h0);
		$display("test fixed codes done");
		for (i = 0; i < 16; i++) cmd(conv[i], 2'(i[0]));
		for (i = 0; i < 8; i++) cmd({3'h3, 2'(i), 3'h4, 3'(i)}, 2'h1);
		$display("test conversions done");
		cmd(11'h002, 2'h2);
		cmd(11'h002, 2'h3);
		cmd(11'h002, 2'h1);
		notes.push_back({2'h3, 20'h0_0000});
		host.send(16'h0002, 1'b1, 32);
		host.send(16'h0002, 1'b0, 20);
		cmd(11'h01C, 2'h0);
		$display("test address and check value done");
		for (i = 0; i < 24; i++) begin
			@(posedge i_clock);
			addr <= 4'($random(seed));
			@(posedge i_clock);
			cmd(11'($random(seed)), 2'($random(seed)));
		end
		$display("test random codes done");
		repeat (20) @(posedge i_clock);
		cmp(22'(notes.size()), 22'h00_0000);
		cmp(22'h00_0000, {21'h00_0000, fa});
		end_of_test();
	end
endmodule
`default_nettype wire

// [bench/mcd_host.sv]
// Host model that frames command words on the serial link.
// Assumes the decoder samples the link pins with its own clock.
`timescale 1ns/1ns
`default_nettype none
module mcd_host (
	output logic o_sck,
	output logic o_csb_n,
	output logic o_sdi
);
	// ----------------------------------------
	// Link framing
	// ----------------------------------------
	initial begin
		o_sck = 1'b0;
		o_csb_n = 1'b1;
		o_sdi = 1'b0;
	end

	function automatic logic [15:0] crc(input logic [15:0] w);
		logic [15:0] r;
		r = mcd_pkg::PEC_SEED;
		for (int i = 15; i >= 0; i--) begin
			r = (r[15] ^ w[i]) ? {r[14:0], 1'b0} ^ mcd_pkg::PEC_POLY : {r[14:0], 1'b0};
		end
		return r;
	endfunction

	// Sends nbits of word and check value, MSB first; bad spoils the check value
	task automatic send(input logic [15:0] word, input logic bad, input int nbits);
		logic [31:0] f;
		f = {word, crc(word) ^ {15'h0000, bad}};
		#1 o_csb_n = 1'b0;
		#20;
		for (int i = 0; i < nbits; i++) begin
			o_sdi = f[31 - i];
			#16 o_sck = 1'b1;
			#16 o_sck = 1'b0;
		end
		o_sdi = ~o_sdi;
		#8 o_csb_n = 1'b1;
		#39;
	endtask
endmodule
`default_nettype wire

// [core/mcd_decoder.sv]
// Receives the command frame from the serial link and decodes the command.
// Assumes link pins and address straps are asynchronous to i_clock.
`timescale 1ns/1ns
`default_nettype none
// Function
// [RULE1] Broadcast: first byte bits 7..3 zero
// [RULE2] Addressed: bit 7 set, address bits 6..3
// [RULE3] Act on addressed only when address matches
// [RULE4] Check value covers both command bytes
// [RULE5] Decode config write, read, cell reads A-H
// [RULE6] Decode other reads, clears, poll, diagnosis
// [RULE7] Cell conversion with mode and selection
// [RULE8] Cell selection: zero all, 1..36, else invalid
// [RULE9] Open-wire conversion, bit 8 picks current
// [RULE10] Cell plus sum conversion on 110000
// [RULE11] Cell self-test, pattern 01 or 10
// [RULE12] Aux conversion, channel in bits 2..0
// [RULE13] Aux channel field meaning, all eight values
// [RULE14] Aux plus sum conversion on 110000
// [RULE15] Aux self-test on 110111
// [RULE16] Status conversion, channel in bits 2..0
// [RULE17] Status channel above 011 is invalid
// [RULE18] Status self-test on all ones
// [RULE19] Mode field: fast, normal, alternate, filtered
// [RULE20] Unknown code or prefix takes no action
module mcd_decoder #(
	parameter int unsigned CELL_COUNT = 36
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_link_sck,
	input wire logic i_link_csb_n,
	input wire logic i_link_sdi,
	input wire logic [3:0] i_device_address,
	output mcd_pkg::mcd_cmd_s o_cmd,
	output logic o_cmd_valid,
	output logic o_pec_error,
	output logic o_cmd_ignored,
	output logic o_frame_active
);
	// ----------------------------------------
	// Parameter check
	// ----------------------------------------
	if (CELL_COUNT < 1 || CELL_COUNT > 36) begin : g_chk
		$error("mcd_decoder: cell count must be 1 to 36");
	end

	localparam logic [5:0] CELL_LIMIT = 6'(CELL_COUNT);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		mcd_pkg::mcd_state_e st;
		logic sck_prev;
		logic [5:0] cnt;
		logic [15:0] shift;
		logic [15:0] word;
		logic [3:0] addr;
		logic pec_load;
		mcd_pkg::mcd_cmd_s cmd;
		logic cmd_valid;
		logic pec_err;
		logic ignored;
		logic frame;
	} mcd_core_s;

	mcd_core_s core_reg;
	mcd_core_s core_next;

	mcd_pkg::mcd_link_s link_raw;
	mcd_pkg::mcd_link_s link_s;
	logic [3:0] addr_s;
	logic [15:0] pec_calc;

	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	assign link_raw.sck = i_link_sck;
	assign link_raw.csb_n = i_link_csb_n;
	assign link_raw.sdi = i_link_sdi;

	mcd_sync #(
		.W($bits(mcd_pkg::mcd_link_s))
	) u_link_sync (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_async(link_raw),
		.o_sync(link_s)
	);

	mcd_sync #(
		.W(4)
	) u_addr_sync (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_async(i_device_address),
		.o_sync(addr_s)
	);

	// ----------------------------------------
	// Check value
	// ----------------------------------------
	mcd_pec u_pec (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_load(core_reg.pec_load),
		.i_word(core_reg.word),
		.o_pec(pec_calc)
	);

	// ----------------------------------------
	// Command code decode
	// ----------------------------------------
	function automatic mcd_pkg::mcd_cmd_s decode_code(input logic [10:0] cc);
		mcd_pkg::mcd_cmd_s d;
		logic [5:0] lo;
		logic [1:0] hi;
		logic st_ok;
		d = '0;
		lo = cc[5:0];
		hi = cc[9:8];
		st_ok = (hi == mcd_pkg::ST_ONE) || (hi == mcd_pkg::ST_TWO);
		d.kind = mcd_pkg::K_NONE;
		d.mode = mcd_pkg::mcd_mode_e'(cc[7:6]); // [RULE19]
		d.field_ok = 1'b1;
		if (cc == mcd_pkg::CODE_WR_CFG) begin
			d.kind = mcd_pkg::K_WR_CFG; // [RULE5]
		end else if (cc == mcd_pkg::CODE_RD_CFG) begin
			d.kind = mcd_pkg::K_RD_CFG; // [RULE5]
		end else if (cc >= mcd_pkg::CODE_RD_CELL_A && cc <= mcd_pkg::CODE_RD_CELL_I) begin
			d.kind = mcd_pkg::K_RD_CELL; // [RULE5] [RULE6]
			d.group = 4'(cc - mcd_pkg::CODE_RD_CELL_A);
		end else if (cc >= mcd_pkg::CODE_RD_AUX_A && cc <= mcd_pkg::CODE_RD_AUX_B) begin
			d.kind = mcd_pkg::K_RD_AUX; // [RULE6]
			d.group = 4'(cc - mcd_pkg::CODE_RD_AUX_A);
		end else if (cc >= mcd_pkg::CODE_RD_STAT_A && cc <= mcd_pkg::CODE_RD_STAT_C) begin
			d.kind = mcd_pkg::K_RD_STAT; // [RULE6]
			d.group = 4'(cc - mcd_pkg::CODE_RD_STAT_A);
		end else if (cc == mcd_pkg::CODE_CLR_CELL) begin
			d.kind = mcd_pkg::K_CLR_CELL; // [RULE6]
		end else if (cc == mcd_pkg::CODE_CLR_AUX) begin
			d.kind = mcd_pkg::K_CLR_AUX; // [RULE6]
		end else if (cc == mcd_pkg::CODE_CLR_STAT) begin
			d.kind = mcd_pkg::K_CLR_STAT; // [RULE6]
		end else if (cc == mcd_pkg::CODE_POLL) begin
			d.kind = mcd_pkg::K_POLL; // [RULE6]
		end else if (cc == mcd_pkg::CODE_DIAG) begin
			d.kind = mcd_pkg::K_DIAG; // [RULE6]
		end else if (cc[10]) begin
			if (lo == mcd_pkg::LO_ALL_ONES && st_ok) begin
				d.kind = mcd_pkg::K_CELL_ST; // [RULE11]
				d.selftest_pattern_field = hi;
			end else if (hi == 2'h0 && lo == mcd_pkg::LO_SUM) begin
				d.kind = mcd_pkg::K_CELL_SUM; // [RULE10]
			end else if (hi == 2'h0) begin
				d.kind = mcd_pkg::K_CELL_CONV; // [RULE7]
				d.cell_select_field = lo;
				d.field_ok = (lo <= mcd_pkg::CELL_MAX) && (lo <= CELL_LIMIT); // [RULE8]
			end else if (cc[9]) begin
				d.kind = mcd_pkg::K_OPEN_WIRE; // [RULE9]
				d.test_current_direction = cc[8];
				d.cell_select_field = lo;
				d.field_ok = (lo <= mcd_pkg::CELL_MAX) && (lo <= CELL_LIMIT); // [RULE8]
			end
		end else begin
			if (lo == mcd_pkg::LO_ALL_ONES) begin
				d.kind = mcd_pkg::K_STAT_ST; // [RULE18]
				d.selftest_pattern_field = hi;
				d.field_ok = st_ok;
			end else if (lo == mcd_pkg::LO_AUX_ST) begin
				d.kind = mcd_pkg::K_AUX_ST; // [RULE15]
				d.selftest_pattern_field = hi;
				d.field_ok = st_ok;
			end else if (hi == 2'h3 && lo == mcd_pkg::LO_SUM) begin
				d.kind = mcd_pkg::K_AUX_SUM; // [RULE14]
			end else if (hi == 2'h3 && lo[5:3] == mcd_pkg::AUX_PFX) begin
				d.kind = mcd_pkg::K_AUX_CONV; // [RULE12]
				d.aux_channel_field = lo[2:0]; // [RULE13]
			end else if (hi == 2'h3 && lo[5:3] == mcd_pkg::STAT_PFX) begin
				d.kind = mcd_pkg::K_STAT_CONV; // [RULE16]
				d.status_channel_field = lo[2:0];
				d.field_ok = lo[2:0] <= mcd_pkg::STAT_MAX; // [RULE17]
			end
		end
		if (d.kind == mcd_pkg::K_NONE) begin
			d = '0;
		end
		return d;
	endfunction

	// ----------------------------------------
	// Frame receiver
	// ----------------------------------------
	always_comb begin
		logic rise;
		logic [15:0] rx;
		logic [7:0] b0;
		logic bcast;
		logic hit;
		mcd_pkg::mcd_cmd_s dec;
		rise = link_s.sck & ~core_reg.sck_prev;
		rx = {core_reg.shift[14:0], link_s.sdi};
		b0 = core_reg.word[15:8];
		bcast = b0[7:3] == mcd_pkg::BCAST_PREFIX; // [RULE1]
		hit = b0[mcd_pkg::ADDR_FLAG_POS]
			&& (b0[mcd_pkg::ADDR_HI_POS:mcd_pkg::ADDR_LO_POS] == core_reg.addr); // [RULE2] [RULE3]
		dec = decode_code(core_reg.word[mcd_pkg::CODE_W-1:0]);
		core_next = core_reg;
		core_next.sck_prev = link_s.sck;
		core_next.pec_load = 1'b0;
		core_next.cmd_valid = 1'b0;
		core_next.pec_err = 1'b0;
		core_next.ignored = 1'b0;
		case (core_reg.st)
			mcd_pkg::ST_IDLE: begin
				core_next.frame = 1'b0;
				if (!link_s.csb_n) begin
					core_next.st = mcd_pkg::ST_RECV;
					core_next.cnt = '0;
					core_next.addr = addr_s;
					core_next.frame = 1'b1;
				end
			end
			mcd_pkg::ST_RECV: begin
				if (link_s.csb_n) begin
					core_next.st = mcd_pkg::ST_IDLE;
					core_next.frame = 1'b0;
				end else if (rise) begin
					core_next.shift = rx;
					core_next.cnt = 6'(core_reg.cnt + 6'h01);
					if (core_reg.cnt == 6'(mcd_pkg::CMD_BITS - 6'h01)) begin
						core_next.word = rx;
						core_next.pec_load = 1'b1; // [RULE4]
					end
					if (core_reg.cnt == 6'(mcd_pkg::FRAME_BITS - 6'h01)) begin
						core_next.st = mcd_pkg::ST_HOLD;
						if (rx != pec_calc) begin
							core_next.pec_err = 1'b1; // [RULE4]
						end else if ((bcast || hit) && dec.kind != mcd_pkg::K_NONE) begin
							core_next.cmd = dec;
							core_next.cmd.broadcast = bcast;
							core_next.cmd_valid = 1'b1;
						end else begin
							core_next.ignored = 1'b1; // [RULE20] [RULE3]
						end
					end
				end
			end
			mcd_pkg::ST_HOLD: begin
				if (link_s.csb_n) begin
					core_next.st = mcd_pkg::ST_IDLE;
					core_next.frame = 1'b0;
				end
			end
			default: begin
				core_next.st = mcd_pkg::ST_IDLE;
				core_next.frame = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			core_reg <= '0;
			core_reg.st <= mcd_pkg::ST_IDLE;
			core_reg.sck_prev <= 1'b0;
			core_reg.addr <= mcd_pkg::ADDR_RST;
		end else begin
			core_reg <= core_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_cmd = core_reg.cmd;
	assign o_cmd_valid = core_reg.cmd_valid;
	assign o_pec_error = core_reg.pec_err;
	assign o_cmd_ignored = core_reg.ignored;
	assign o_frame_active = core_reg.frame;
endmodule
`default_nettype wire

// [core/mcd_pec.sv]
// Check value over the sixteen-bit command word, most significant bit first.
// Assumes i_load is a one-cycle pulse with i_word stable in that cycle.
`timescale 1ns/1ns
`default_nettype none
module mcd_pec #(
	parameter logic [15:0] POLY = mcd_pkg::PEC_POLY,
	parameter logic [15:0] SEED = mcd_pkg::PEC_SEED
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_load,
	input wire logic [15:0] i_word,
	output logic [15:0] o_pec
);
	typedef struct packed {
		logic [15:0] pec;
	} mcd_pec_s;

	mcd_pec_s pec_reg;
	mcd_pec_s pec_next;

	if (!POLY[0]) begin : g_chk
		$error("mcd_pec: polynomial must have its lowest term set");
	end

	always_comb begin
		logic [15:0] c;
		logic fb;
		c = SEED;
		fb = 1'b0;
		pec_next = pec_reg;
		for (int i = 15; i >= 0; i--) begin
			fb = c[15] ^ i_word[i];
			c = {c[14:0], 1'b0};
			if (fb) begin
				c = c ^ POLY;
			end
		end
		if (i_load) begin
			pec_next.pec = c;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			pec_reg <= '0;
		end else begin
			pec_reg <= pec_next;
		end
	end

	assign o_pec = pec_reg.pec;
endmodule
`default_nettype wire

// [core/mcd_pkg.sv]
// Constants, types and carriers of the monitor command decoder.
// Assumes one core clock; the link pins arrive from another domain.
package mcd_pkg;

	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int unsigned CODE_W = 11;
	localparam logic [5:0] CMD_BITS = 6'h10;
	localparam logic [5:0] FRAME_BITS = 6'h20;
	localparam int unsigned ADDR_FLAG_POS = 7;
	localparam int unsigned ADDR_HI_POS = 6;
	localparam int unsigned ADDR_LO_POS = 3;
	localparam logic [4:0] BCAST_PREFIX = 5'h00;

	// ----------------------------------------
	// Fixed command codes
	// ----------------------------------------
	localparam logic [10:0] CODE_WR_CFG = 11'h001;
	localparam logic [10:0] CODE_RD_CFG = 11'h002;
	localparam logic [10:0] CODE_RD_CELL_A = 11'h004;
	localparam logic [10:0] CODE_RD_CELL_I = 11'h00C;
	localparam logic [10:0] CODE_RD_AUX_A = 11'h010;
	localparam logic [10:0] CODE_RD_AUX_B = 11'h011;
	localparam logic [10:0] CODE_RD_STAT_A = 11'h014;
	localparam logic [10:0] CODE_RD_STAT_C = 11'h016;
	localparam logic [10:0] CODE_CLR_CELL = 11'h019;
	localparam logic [10:0] CODE_CLR_AUX = 11'h01A;
	localparam logic [10:0] CODE_CLR_STAT = 11'h01B;
	localparam logic [10:0] CODE_POLL = 11'h01C;
	localparam logic [10:0] CODE_DIAG = 11'h01D;

	// ----------------------------------------
	// Conversion field patterns
	// ----------------------------------------
	localparam logic [5:0] LO_SUM = 6'h30;
	localparam logic [5:0] LO_ALL_ONES = 6'h3F;
	localparam logic [5:0] LO_AUX_ST = 6'h37;
	localparam logic [2:0] AUX_PFX = 3'h4;
	localparam logic [2:0] STAT_PFX = 3'h5;
	localparam logic [5:0] CELL_MAX = 6'h24;
	localparam logic [2:0] STAT_MAX = 3'h3;
	localparam logic [1:0] ST_ONE = 2'h1;
	localparam logic [1:0] ST_TWO = 2'h2;

	// ----------------------------------------
	// Check value and reset values
	// ----------------------------------------
	localparam logic [15:0] PEC_POLY = 16'h8005;
	localparam logic [15:0] PEC_SEED = 16'h0000;
	localparam logic [3:0] ADDR_RST = 4'h0;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RECV = 3'b010,
		ST_HOLD = 3'b100
	} mcd_state_e;

	typedef enum logic [1:0] {
		MODE_FAST = 2'h0,
		MODE_NORMAL = 2'h1,
		MODE_ALTERNATE = 2'h2,
		MODE_FILTERED = 2'h3
	} mcd_mode_e;

	typedef enum logic [4:0] {
		K_NONE, K_WR_CFG, K_RD_CFG, K_RD_CELL, K_RD_AUX, K_RD_STAT,
		K_CLR_CELL, K_CLR_AUX, K_CLR_STAT, K_POLL, K_DIAG,
		K_CELL_CONV, K_OPEN_WIRE, K_CELL_SUM, K_CELL_ST,
		K_AUX_CONV, K_AUX_SUM, K_AUX_ST, K_STAT_CONV, K_STAT_ST
	} mcd_kind_e;

	typedef struct packed {
		logic sck;
		logic csb_n;
		logic sdi;
	} mcd_link_s;

	typedef struct packed {
		mcd_kind_e kind;
		logic broadcast;
		logic [3:0] group;
		mcd_mode_e mode;
		logic [5:0] cell_select_field;
		logic test_current_direction;
		logic [1:0] selftest_pattern_field;
		logic [2:0] aux_channel_field;
		logic [2:0] status_channel_field;
		logic field_ok;
	} mcd_cmd_s;

endpackage

// [core/mcd_sync.sv]
// Two-stage synchroniser for a group of pins.
// Assumes the inputs are asynchronous to i_clock.
`timescale 1ns/1ns
`default_nettype none
module mcd_sync #(
	parameter int unsigned W = 1
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} mcd_sync_s;

	mcd_sync_s sync_reg;
	mcd_sync_s sync_next;

	if (W < 1) begin : g_chk
		$error("mcd_sync: width must be at least one");
	end

	always_comb begin
		sync_next.s1 = i_async;
		sync_next.s2 = sync_reg.s1;
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign o_sync = sync_reg.s2;
endmodule
`default_nettype wire
